// *** hw/ddc_pkg.sv ***
package ddc_pkg;
  // Bus and datapath widths
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned STRB_W = 4;
  localparam int unsigned CODE_W = 8;
  localparam int unsigned HALT_W = 16;
  localparam int unsigned NUM_CH = 2;

  // Register index slice of the byte address (byte address = 4 * index)
  localparam int unsigned IDX_LSB = 2;
  localparam int unsigned IDX_MSB = 17;

  // Register indices, low 16 bits
  localparam logic [15:0] IDX_HALT = 16'hff3c;
  localparam logic [15:0] IDX_CODE0 = 16'hffa4;
  localparam logic [15:0] IDX_CODE1 = 16'hffa5;
  localparam logic [15:0] IDX_CTRL = 16'hffa6;

  // Reset values
  localparam logic [HALT_W-1:0] HALT_RST = 16'h3fff;
  localparam logic [CODE_W-1:0] CODE_RST = 8'h00;
  localparam logic [NUM_CH-1:0] OE_RST = 2'h0;
  localparam logic JOINT_RST = 1'h0;

  // Field positions
  localparam int unsigned HALT_BIT = 10;
  localparam int unsigned CTRL_OE1_BIT = 7;
  localparam int unsigned CTRL_OE0_BIT = 6;
  localparam int unsigned CTRL_JOINT_BIT = 5;
  localparam int unsigned CTRL_RSVD_W = 5;
  localparam logic [CTRL_RSVD_W-1:0] CTRL_RSVD = 5'h1f;

  // Byte lanes
  localparam int unsigned LANE0 = 0;
  localparam int unsigned LANE1 = 1;

  // Response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** hw/ddc_top.sv ***
// Behaviour
// - Two 8-bit software read/write channel code registers
// - Enabled channel continuously converts and drives code
// - Reset and hardware standby clear code registers
// - Registers decoded on low 16 index bits
// - Starts halted; software releases before access
// - Software standby holds enabled outputs unchanged
// - Bit7 enables channel 1, bit6 channel 0
// - Joint bit: either enable converts both channels
// - Write while enabled converts new code at once
// - Halt bit stops converter and blocks accesses
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ns
`default_nettype none

module ddc_top
  import ddc_pkg::*;
(
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RESETN_I,
  // Power mode requests from the system controller
  input wire logic HW_STANDBY_I,
  input wire logic SW_STANDBY_I,
  // AXI4-Lite write address
  input wire logic [ADDR_W-1:0] AWADDR_I,
  input wire logic AWVALID_I,
  output logic AWREADY_O,
  // AXI4-Lite write data
  input wire logic [DATA_W-1:0] WDATA_I,
  input wire logic [STRB_W-1:0] WSTRB_I,
  input wire logic WVALID_I,
  output logic WREADY_O,
  // AXI4-Lite write response
  output logic [1:0] BRESP_O,
  output logic BVALID_O,
  input wire logic BREADY_I,
  // AXI4-Lite read address
  input wire logic [ADDR_W-1:0] ARADDR_I,
  input wire logic ARVALID_I,
  output logic ARREADY_O,
  // AXI4-Lite read data
  output logic [DATA_W-1:0] RDATA_O,
  output logic [1:0] RRESP_O,
  output logic RVALID_O,
  input wire logic RREADY_I,
  // Converter core side
  output logic [CODE_W-1:0] CH0_CODE_O,
  output logic [CODE_W-1:0] CH1_CODE_O,
  output logic [NUM_CH-1:0] CONV_EN_O,
  output logic [NUM_CH-1:0] OUT_EN_O,
  output logic [NUM_CH-1:0] CODE_LOAD_O,
  output logic HALTED_O
);

  // Reset synchroniser
  logic [1:0] rst_sync_reg;
  logic rst_n;

  // Register file
  logic [HALT_W-1:0] halt_reg;
  logic [HALT_W-1:0] halt_next;
  logic [CODE_W-1:0] code_reg [NUM_CH];
  logic [NUM_CH-1:0] oe_reg;
  logic joint_reg;

  // Write channel capture
  logic aw_hold_reg;
  logic w_hold_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [DATA_W-1:0] wdata_reg;
  logic [STRB_W-1:0] wstrb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;

  // Read channel
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [DATA_W-1:0] rdata_reg;

  // Converter side flops
  logic [CODE_W-1:0] code_out_reg [NUM_CH];
  logic [NUM_CH-1:0] conv_en_reg;
  logic [NUM_CH-1:0] out_en_reg;
  logic [NUM_CH-1:0] load_reg;
  logic [NUM_CH-1:0] code_wr_d_reg;

  // Release reset through two flops, assert at once
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'h1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // Module halt state
  logic halted;
  assign halted = halt_reg[HALT_BIT];

  // Write address decode on the captured address
  logic [15:0] w_idx;
  logic w_hit_halt;
  logic w_hit_code0;
  logic w_hit_code1;
  logic w_hit_ctrl;
  logic w_mapped;
  assign w_idx = awaddr_reg[IDX_MSB:IDX_LSB];
  assign w_hit_halt = (w_idx == IDX_HALT);
  assign w_hit_code0 = (w_idx == IDX_CODE0);
  assign w_hit_code1 = (w_idx == IDX_CODE1);
  assign w_hit_ctrl = (w_idx == IDX_CTRL);
  assign w_mapped = w_hit_halt | w_hit_code0 | w_hit_code1 | w_hit_ctrl;

  // Write strobes; converter registers are locked while halted
  logic wr_fire;
  logic wr_halt;
  logic wr_ctrl;
  logic [NUM_CH-1:0] wr_code;
  assign wr_fire = aw_hold_reg & w_hold_reg & ~bvalid_reg;
  assign wr_halt = wr_fire & w_hit_halt;
  assign wr_ctrl = wr_fire & w_hit_ctrl & ~halted & wstrb_reg[LANE0];
  assign wr_code[0] = wr_fire & w_hit_code0 & ~halted & wstrb_reg[LANE0];
  assign wr_code[1] = wr_fire & w_hit_code1 & ~halted & wstrb_reg[LANE0];

  // Halt register honours both byte lanes
  assign halt_next[15:8] = wstrb_reg[LANE1] ? wdata_reg[15:8] : halt_reg[15:8];
  assign halt_next[7:0] = wstrb_reg[LANE0] ? wdata_reg[7:0] : halt_reg[7:0];

  // Ready while the channel slot is free and no response is pending
  assign AWREADY_O = ~aw_hold_reg & ~bvalid_reg;
  assign WREADY_O = ~w_hold_reg & ~bvalid_reg;
  assign BVALID_O = bvalid_reg;
  assign BRESP_O = bresp_reg;

  // Capture address and data in either order, answer once both are in
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      aw_hold_reg <= 1'h0;
      w_hold_reg <= 1'h0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
      bvalid_reg <= 1'h0;
      bresp_reg <= RESP_OKAY;
    end else begin
      if (AWVALID_I && AWREADY_O) begin
        aw_hold_reg <= 1'h1;
        awaddr_reg <= AWADDR_I;
      end
      if (WVALID_I && WREADY_O) begin
        w_hold_reg <= 1'h1;
        wdata_reg <= WDATA_I;
        wstrb_reg <= WSTRB_I;
      end
      if (wr_fire) begin
        aw_hold_reg <= 1'h0;
        w_hold_reg <= 1'h0;
        bvalid_reg <= 1'h1;
        bresp_reg <= w_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_reg && BREADY_I) begin
        bvalid_reg <= 1'h0;
      end
    end
  end

  // Halt register; hardware standby restores its initial value
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      halt_reg <= HALT_RST;
    end else if (HW_STANDBY_I) begin
      halt_reg <= HALT_RST;
    end else if (wr_halt) begin
      halt_reg <= halt_next;
    end
  end

  // Control register; reserved bits are not stored
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      oe_reg <= OE_RST;
      joint_reg <= JOINT_RST;
    end else if (HW_STANDBY_I) begin
      oe_reg <= OE_RST;
      joint_reg <= JOINT_RST;
    end else if (wr_ctrl) begin
      oe_reg[1] <= wdata_reg[CTRL_OE1_BIT];
      oe_reg[0] <= wdata_reg[CTRL_OE0_BIT];
      joint_reg <= wdata_reg[CTRL_JOINT_BIT];
    end
  end

  // Conversion and output enables per channel
  logic any_oe;
  logic [NUM_CH-1:0] conv_en_w;
  logic [NUM_CH-1:0] out_en_w;
  assign any_oe = |oe_reg;

  // Per-channel code register and converter drive
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
      // Joint mode lets either enable run both converters
      assign conv_en_w[ch] = ~halted & (oe_reg[ch] | (joint_reg & any_oe));
      assign out_en_w[ch] = ~halted & oe_reg[ch];

      // Code register, cleared by reset and hardware standby
      always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
          code_reg[ch] <= CODE_RST;
          code_wr_d_reg[ch] <= 1'h0;
        end else if (HW_STANDBY_I) begin
          code_reg[ch] <= CODE_RST;
          code_wr_d_reg[ch] <= 1'h0;
        end else begin
          if (wr_code[ch]) begin
            code_reg[ch] <= wdata_reg[CODE_W-1:0];
          end
          // A code written in software standby stays pending until the hold ends
          code_wr_d_reg[ch] <= wr_code[ch] | (code_wr_d_reg[ch] & SW_STANDBY_I);
        end
      end

      // Converter drive; frozen during software standby
      always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
          code_out_reg[ch] <= CODE_RST;
          conv_en_reg[ch] <= 1'h0;
          out_en_reg[ch] <= 1'h0;
          load_reg[ch] <= 1'h0;
        end else if (HW_STANDBY_I) begin
          code_out_reg[ch] <= CODE_RST;
          conv_en_reg[ch] <= 1'h0;
          out_en_reg[ch] <= 1'h0;
          load_reg[ch] <= 1'h0;
        end else if (SW_STANDBY_I) begin
          load_reg[ch] <= 1'h0;
        end else begin
          conv_en_reg[ch] <= conv_en_w[ch];
          out_en_reg[ch] <= out_en_w[ch];
          if (conv_en_w[ch]) begin
            code_out_reg[ch] <= code_reg[ch];
          end
          // Start a conversion on a fresh code or when enabled
          load_reg[ch] <= conv_en_w[ch] & (code_wr_d_reg[ch] | ~conv_en_reg[ch]);
        end
      end
    end
  endgenerate

  // Converter outputs
  assign CH0_CODE_O = code_out_reg[0];
  assign CH1_CODE_O = code_out_reg[1];
  assign CONV_EN_O = conv_en_reg;
  assign OUT_EN_O = out_en_reg;
  assign CODE_LOAD_O = load_reg;
  assign HALTED_O = halted;

  // Read address decode straight from the bus
  logic [15:0] r_idx;
  logic r_hit_halt;
  logic r_hit_code0;
  logic r_hit_code1;
  logic r_hit_ctrl;
  logic r_mapped;
  logic r_locked;
  logic [CODE_W-1:0] ctrl_word;
  logic [DATA_W-1:0] rd_word;
  assign r_idx = ARADDR_I[IDX_MSB:IDX_LSB];
  assign r_hit_halt = (r_idx == IDX_HALT);
  assign r_hit_code0 = (r_idx == IDX_CODE0);
  assign r_hit_code1 = (r_idx == IDX_CODE1);
  assign r_hit_ctrl = (r_idx == IDX_CTRL);
  assign r_mapped = r_hit_halt | r_hit_code0 | r_hit_code1 | r_hit_ctrl;
  assign r_locked = halted & ~r_hit_halt;
  assign ctrl_word = {oe_reg[1], oe_reg[0], joint_reg, CTRL_RSVD};

  // Read mux; a locked register reads as zero
  assign rd_word = r_locked ? '0 :
                   r_hit_halt ? {{(DATA_W-HALT_W){1'h0}}, halt_reg} :
                   r_hit_code0 ? {{(DATA_W-CODE_W){1'h0}}, code_reg[0]} :
                   r_hit_code1 ? {{(DATA_W-CODE_W){1'h0}}, code_reg[1]} :
                   r_hit_ctrl ? {{(DATA_W-CODE_W){1'h0}}, ctrl_word} :
                   '0;

  // Read channel handshake
  assign ARREADY_O = ~rvalid_reg;
  assign RVALID_O = rvalid_reg;
  assign RDATA_O = rdata_reg;
  assign RRESP_O = rresp_reg;

  // Answer one cycle after the address is taken; reads change nothing
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_reg <= 1'h0;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
    end else if (ARVALID_I && ARREADY_O) begin
      rvalid_reg <= 1'h1;
      rdata_reg <= rd_word;
      rresp_reg <= r_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_reg && RREADY_I) begin
      rvalid_reg <= 1'h0;
    end
  end

endmodule

`default_nettype wire

// *** test/ddc_top_assertions.sv ***
`timescale 1ns/1ns
`default_nettype none
module ddc_chk
  import ddc_pkg::*;
(
  // Clock, reset, modes and handshakes
  input wire logic CLK_I, RESETN_I, HW_STANDBY_I, SW_STANDBY_I, HALTED_O,
  input wire logic BVALID_O, BREADY_I, ARVALID_I, ARREADY_O, RVALID_O, RREADY_I,
  // Answers and converter side
  input wire logic [1:0] BRESP_O,
  input wire logic [DATA_W-1:0] RDATA_O,
  input wire logic [CODE_W-1:0] CH0_CODE_O,
  input wire logic [NUM_CH-1:0] CONV_EN_O, OUT_EN_O, CODE_LOAD_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RESETN_I);
  // Hardware standby seen on two edges
  sequence hw_held_s;
    HW_STANDBY_I ##1 HW_STANDBY_I;
  endsequence
  // Bus answers stand until taken; a read is answered the next cycle
  bresp_hold_a: assert property (BVALID_O && !BREADY_I |=> BVALID_O && $stable(BRESP_O))
    else $error("write response changed before taken");
  rdata_hold_a: assert property (RVALID_O && !RREADY_I |=> RVALID_O && $stable(RDATA_O))
    else $error("read data changed before taken");
  read_answer_a: assert property (ARVALID_I && ARREADY_O |=> RVALID_O)
    else $error("read not answered in one cycle");
  // Converter enables, load pulse, standby hold and clear
  halt_stops_a: assert property (HALTED_O |=> CONV_EN_O == 2'h0 && OUT_EN_O == 2'h0)
    else $error("converter runs while halted");
  out_conv_a: assert property ((OUT_EN_O & ~CONV_EN_O) == 2'h0)
    else $error("output driven without conversion");
  conv_split_a: assert property (CONV_EN_O[0] != CONV_EN_O[1] |-> OUT_EN_O == CONV_EN_O)
    else $error("single conversion does not match output");
  load_pulse_a: assert property (CODE_LOAD_O[0] |=> !CODE_LOAD_O[0])
    else $error("load pulse longer than one cycle");
  standby_freeze_a: assert property (SW_STANDBY_I |=> $stable(CH0_CODE_O) && $stable(OUT_EN_O) && !CODE_LOAD_O)
    else $error("outputs moved in software standby");
  hw_clear_a: assert property (hw_held_s |=> HALTED_O && CONV_EN_O == 2'h0 && OUT_EN_O == 2'h0 && CH0_CODE_O == CODE_RST)
    else $error("hardware standby did not clear");
endmodule
bind ddc_top ddc_chk i_chk (.*);
`default_nettype wire

// *** test/tb_ddc_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_ddc_top;
  import ddc_pkg::*;
  logic CLK_I = 0, RESETN_I = 0, HW_STANDBY_I = 0, SW_STANDBY_I = 0;
  logic AWVALID_I = 0, WVALID_I = 0, BREADY_I = 0, ARVALID_I = 0, RREADY_I = 0;
  logic [ADDR_W-1:0] AWADDR_I = '0, ARADDR_I = '0;
  logic [DATA_W-1:0] WDATA_I = '0, RDATA_O, rdat;
  logic [STRB_W-1:0] WSTRB_I = '0;
  logic AWREADY_O, WREADY_O, BVALID_O, ARREADY_O, RVALID_O, HALTED_O;
  logic [1:0] BRESP_O, RRESP_O, resp;
  logic [CODE_W-1:0] CH0_CODE_O, CH1_CODE_O;
  logic [NUM_CH-1:0] CONV_EN_O, OUT_EN_O, CODE_LOAD_O;
  int errors = 0, tests_run = 0;
  localparam logic [31:0] A_HALT = 32'h3fcf0, A_C0 = 32'h3fe90, A_C1 = 32'h3fe94, A_CTRL = 32'h3fe98;
  typedef struct {logic [31:0] a, d, q; logic [1:0] r, cv, oe;} ddc_row_t;
  // Address, write data, read back, response, conversion and output enables
  ddc_row_t rows [10] = '{'{A_HALT, 32'h3bff, 32'h3bff, RESP_OKAY, 2'h0, 2'h0},
    '{A_C0, 32'ha5, 32'ha5, RESP_OKAY, 2'h0, 2'h0}, '{A_C1, 32'h3c, 32'h3c, RESP_OKAY, 2'h0, 2'h0},
    '{A_CTRL, 32'h40, 32'h5f, RESP_OKAY, 2'h1, 2'h1}, '{A_CTRL, 32'h80, 32'h9f, RESP_OKAY, 2'h2, 2'h2},
    '{A_CTRL, 32'h60, 32'h7f, RESP_OKAY, 2'h3, 2'h1}, '{A_CTRL, 32'ha0, 32'hbf, RESP_OKAY, 2'h3, 2'h2},
    '{A_CTRL, 32'h20, 32'h3f, RESP_OKAY, 2'h0, 2'h0}, '{A_CTRL, 32'hc0, 32'hdf, RESP_OKAY, 2'h3, 2'h3},
    '{32'h3fe9c, 32'h1, 32'h0, RESP_SLVERR, 2'h3, 2'h3}};
  ddc_top i_dut (.*);
  // Clock
  always #50 CLK_I = ~CLK_I;
  task automatic chk(input string n, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [31:0] a, d);
    logic ta, tw;
    @(posedge CLK_I);
    AWADDR_I <= a;
    WDATA_I <= d;
    WSTRB_I <= 4'hf;
    AWVALID_I <= 1'h1;
    WVALID_I <= 1'h1;
    BREADY_I <= 1'h1;
    @(negedge CLK_I);
    while (AWVALID_I | WVALID_I) begin
      ta = AWREADY_O & AWVALID_I;
      tw = WREADY_O & WVALID_I;
      @(posedge CLK_I);
      if (ta) AWVALID_I <= 1'h0;
      if (tw) WVALID_I <= 1'h0;
      @(negedge CLK_I);
    end
    while (!BVALID_O) @(negedge CLK_I);
    resp = BRESP_O;
    @(posedge CLK_I);
    BREADY_I <= 1'h0;
  endtask
  task automatic rd(input logic [31:0] a);
    @(posedge CLK_I);
    ARADDR_I <= a;
    ARVALID_I <= 1'h1;
    RREADY_I <= 1'h1;
    do @(negedge CLK_I); while (!ARREADY_O);
    @(posedge CLK_I);
    ARVALID_I <= 1'h0;
    do @(negedge CLK_I); while (!RVALID_O);
    rdat = RDATA_O;
    resp = RRESP_O;
    @(posedge CLK_I);
    RREADY_I <= 1'h0;
  endtask
  task automatic rc(input string n, input logic [31:0] a, e);
    rd(a);
    chk(n, e, rdat);
  endtask
  task automatic do_reset;
    @(posedge CLK_I);
    RESETN_I <= 1'h0;
    repeat (16) @(posedge CLK_I);
    RESETN_I <= 1'h1;
    repeat (4) @(posedge CLK_I);
  endtask
  task test_done;
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Watchdog
  initial begin
    #500000;
    errors++;
    test_done();
  end
  // Main sequence
  initial begin
    int n;
    do_reset();
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      chk("write resp", rows[i].r, resp);
      rd(rows[i].a);
      chk("read data", rows[i].q, rdat);
      chk("read resp", rows[i].r, resp);
      chk("conv enable", rows[i].cv, CONV_EN_O);
      chk("out enable", rows[i].oe, OUT_EN_O);
    end
    chk("code 0", 8'ha5, CH0_CODE_O);
    chk("code 1", 8'h3c, CH1_CODE_O);
    // New code while enabled
    wr(A_C0, 32'h11);
    n = 0;
    while (!CODE_LOAD_O[0] && n < 20) begin
      @(negedge CLK_I);
      n++;
    end
    chk("load pulse", 1'h1, CODE_LOAD_O[0]);
    chk("code 0", 8'h11, CH0_CODE_O);
    // Software standby holds outputs
    @(posedge CLK_I) SW_STANDBY_I <= 1'h1;
    wr(A_C0, 32'h22);
    @(negedge CLK_I);
    chk("held code 0", 8'h11, CH0_CODE_O);
    chk("held out enable", 2'h3, OUT_EN_O);
    rc("code 0 reg", A_C0, 32'h22);
    @(posedge CLK_I) SW_STANDBY_I <= 1'h0;
    repeat (2) @(negedge CLK_I);
    chk("resumed load", 1'h1, CODE_LOAD_O[0]);
    chk("resumed code 0", 8'h22, CH0_CODE_O);
    // Halt locks the registers
    wr(A_HALT, 32'h3fff);
    repeat (2) @(negedge CLK_I);
    chk("halted", 1'h1, HALTED_O);
    chk("halted conv", 2'h0, CONV_EN_O);
    wr(A_C0, 32'h77);
    rc("locked read", A_C0, 32'h0);
    wr(A_HALT, 32'h3bff);
    rc("code 0 reg", A_C0, 32'h22);
    // Hardware standby clears
    @(posedge CLK_I) HW_STANDBY_I <= 1'h1;
    repeat (3) @(posedge CLK_I);
    HW_STANDBY_I <= 1'h0;
    rc("halt reg", A_HALT, 32'h3fff);
    wr(A_HALT, 32'h3bff);
    rc("code 0 reg", A_C0, 32'h0);
    // Second reset in mid-run, with channel 1 live
    wr(A_C1, 32'h5a);
    wr(A_CTRL, 32'h80);
    @(negedge CLK_I);
    chk("load pulse 1", 1'h1, CODE_LOAD_O[1]);
    chk("code 1", 8'h5a, CH1_CODE_O);
    do_reset();
    chk("aw ready", 1'h1, AWREADY_O);
    chk("w ready", 1'h1, WREADY_O);
    chk("ar ready", 1'h1, ARREADY_O);
    chk("b valid", 1'h0, BVALID_O);
    chk("r valid", 1'h0, RVALID_O);
    chk("halted", 1'h1, HALTED_O);
    chk("reset conv", 2'h0, CONV_EN_O);
    chk("reset out", 2'h0, OUT_EN_O);
    chk("reset code 1", 8'h0, CH1_CODE_O);
    chk("reset load", 2'h0, CODE_LOAD_O);
    rc("halt reg", A_HALT, 32'h3fff);
    rc("locked ctrl", A_CTRL, 32'h0);
    wr(A_HALT, 32'h3bff);
    rc("code 1 reg", A_C1, 32'h0);
    rc("ctrl reg", A_CTRL, 32'h1f);
    test_done();
  end
endmodule
`default_nettype wire
